// ===== common/sp_params.svh
// register map, field positions, reset values and bit timing of the serial port
// How it works
// - two mode bits pick framing and rate
// - select bit turns bit 7 into error flag
// - bad stop bit sets sticky error flag
// - modes 2/3 multiprocessor drops ninth-bit-zero frames
// - mode 1 multiprocessor needs valid stop
// - mode 0 multiprocessor bit picks divide 4/12
// - receiver works only while enabled
// - modes 2/3 send software ninth bit
// - ninth-bit flag holds bit nine or stop
// - transmit done at stop start; software clears
// - receive done mid stop; software clears
// - data port reads receive, writes transmit
// - masked address compare, zero mask accepts
// - interrupt needs own and global enable
// - baud double bit doubles async rate
// - per-direction timer 1 or 2 source
`ifndef SP_PARAMS_SVH
`define SP_PARAMS_SVH

// register indices, byte address is four times the index
`define SP_IDX_CTRL 8'h98
`define SP_IDX_DATA 8'h99
`define SP_IDX_IE 8'ha8
`define SP_IDX_OWN_STATION_ADDRESS 8'ha9
`define SP_IDX_MASK 8'hb9
`define SP_IDX_PCTL 8'h87
`define SP_IDX_TBSEL 8'hc8

// reset values
`define SP_RST_BYTE 8'h00

// field positions
`define SP_IE_GLOBAL 7
`define SP_IE_SERIAL 4
`define SP_PCTL_DBL 7
`define SP_PCTL_FESEL 6
`define SP_TB_RX 5
`define SP_TB_TX 4

// bus responses
`define SP_RESP_OKAY 2'h0
`define SP_RESP_SLVERR 2'h2

// timing in clocks: mode 0 bit, mode 2 sub-bit tick, sixteen ticks a bit
`define SP_M0_SLOW_CLKS 4'hc
`define SP_M0_FAST_CLKS 4'h4
`define SP_M2_LAST 2'h3
`define SP_M2_LAST_DBL 2'h1
`define SP_PH_MID 4'h7
`define SP_PH_LAST 4'hf

`endif

// ===== common/sp_pkg.sv
// shared types of the serial port block
package sp_pkg;
  typedef logic [7:0] sp_byte_t;  // one register byte
  typedef logic [31:0] sp_word_t;  // bus data word
  typedef logic [11:0] sp_addr_t;  // bus byte address
  // serial control layout, msb first
  typedef struct packed {
    logic modeHi;
    logic modeLo;
    logic mp;
    logic ren;
    logic tb8;
    logic rb8;
    logic ti;
    logic ri;
  } sp_serial_control_t;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_NINTH, TX_STOP, TX_M0} sp_tx_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_NINTH, RX_STOP, RX_M0} sp_rx_t;
endpackage

// ===== hw/sp_serial_port.sv
// serial port with address match, its transmit fifo and bus slave
`timescale 1ns/1ps
`include "sp_params.svh"

// ****************************************
// transmit fifo
// ****************************************
module sp_fifo #(parameter int WIDTH = 8, parameter int DEPTH = 8)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];  // storage, no reset needed
  logic [AW-1:0] wrPtr;  // next slot to fill
  logic [AW-1:0] rdPtr;  // oldest slot
  logic [AW:0] count;  // words held
  wire push = inValid && inReady;
  wire pop = outValid && outReady;
  assign inReady = count != (AW+1)'(DEPTH);
  assign outValid = count != '0;
  assign outData = mem[rdPtr];

  // pointers wrap naturally, depth is a power of two
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
        wrPtr <= wrPtr + 1'b1;
      if (pop)
        rdPtr <= rdPtr + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // write the slot
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wrPtr] <= inData;
  end
endmodule

// ****************************************
// serial port top
// ****************************************
module sp_serial_port
(
  input wire logic clk,
  input wire logic resetn,
  input wire sp_pkg::sp_addr_t awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire sp_pkg::sp_word_t wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire sp_pkg::sp_addr_t araddr,
  input wire logic arvalid,
  output logic arready,
  output sp_pkg::sp_word_t rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic rxd,
  output logic rxdOut,
  output logic rxdOe,
  output logic txd,
  input wire logic timer1Ovf,
  input wire logic timer2Ovf,
  output logic irq
);
  import sp_pkg::*;

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  // ****************************************
  // functions
  // ****************************************
  // register hit on a word-aligned byte address
  function automatic logic hit(input sp_addr_t a, input sp_byte_t idx);
    return a == {2'h0, idx, 2'h0};
  endfunction

  // mode 0 bit length in clocks
  function automatic logic [3:0] m0Len(input logic fast);
    return fast ? `SP_M0_FAST_CLKS : `SP_M0_SLOW_CLKS;
  endfunction

  // sixteenth-of-bit tick for one direction
  function automatic logic baudTick(input logic isM2, input logic m2t, input logic ovf,
                                    input logic dblRate, input logic half);
    return isM2 ? m2t : (ovf && (dblRate || half));
  endfunction

  // ****************************************
  // registers and state
  // ****************************************
  sp_serial_control_t serial_control;  // serial control
  logic feFlag;  // frame error, shares bit 7
  sp_byte_t ie;  // interrupt enables
  sp_byte_t own_station_address;  // own station address
  sp_byte_t smask;  // station mask
  sp_byte_t pctl;  // baud double and error select
  sp_byte_t tbsel;  // timebase selects
  sp_byte_t rxBuf;  // receive side of data port
  sp_addr_t awAddrQ;  // held write address
  sp_byte_t wDataQ;  // held write byte
  logic wLaneQ;  // low byte lane strobe
  sp_tx_t txSt;  // transmit state
  sp_rx_t rxSt;  // receive state
  logic [3:0] txPh;  // tick or clock phase in bit
  logic [3:0] rxPh;
  logic [2:0] txBit;  // data bit index
  logic [2:0] rxBit;
  sp_byte_t txSh;  // transmit shifter, lsb goes out
  sp_byte_t rxSh;  // receive shifter, fills from top
  logic txNinth;  // ninth bit latched at frame start
  logic rxNinth;  // received ninth bit
  logic rxMeta;  // first sync stage, read only by rxS
  logic rxS;  // synchronised receive line
  logic [1:0] m2Cnt;  // mode 2 tick prescaler
  logic txHalf;  // overflow halver, transmit
  logic rxHalf;  // overflow halver, receive

  // ****************************************
  // decoding
  // ****************************************
  // mode selection
  // mode from two bits
  wire [1:0] mode = {serial_control.modeHi, serial_control.modeLo};
  wire m0 = mode == 2'h0;
  wire m1 = mode == 2'h1;
  wire m2 = mode == 2'h2;
  wire m23 = mode[1];
  wire dbl = pctl[`SP_PCTL_DBL];
  wire feSel = pctl[`SP_PCTL_FESEL];
  wire [3:0] m0Last = m0Len(serial_control.mp) - 4'h1;
  wire [3:0] m0Half = m0Len(serial_control.mp) >> 1;
  wire m2Tick = m2Cnt == (dbl ? `SP_M2_LAST_DBL : `SP_M2_LAST);
  wire txOvf = tbsel[`SP_TB_TX] ? timer2Ovf : timer1Ovf;
  wire rxOvf = tbsel[`SP_TB_RX] ? timer2Ovf : timer1Ovf;
  wire txTick = baudTick(m2, m2Tick, txOvf, dbl, txHalf);
  wire rxTick = baudTick(m2, m2Tick, rxOvf, dbl, rxHalf);

  // write side decode, a data port write waits while the fifo is full
  wire wHitCtrl = hit(awAddrQ, `SP_IDX_CTRL);
  wire wHitData = hit(awAddrQ, `SP_IDX_DATA);
  wire wMapped = wHitCtrl || wHitData || hit(awAddrQ, `SP_IDX_IE) ||
                 hit(awAddrQ, `SP_IDX_OWN_STATION_ADDRESS) || hit(awAddrQ, `SP_IDX_MASK) ||
                 hit(awAddrQ, `SP_IDX_PCTL) || hit(awAddrQ, `SP_IDX_TBSEL);
  wire fifoInReady;
  wire doWrite = !awready && !wready && !bvalid && !(wHitData && !fifoInReady);
  wire wrOk = doWrite && wLaneQ;
  wire wrCtrl = wrOk && wHitCtrl;

  // read side decode
  wire rHitData = hit(araddr, `SP_IDX_DATA);
  wire [7:0] ctrlView = {feSel ? feFlag : serial_control.modeHi, serial_control[6:0]};
  wire [7:0] readByte =
    hit(araddr, `SP_IDX_CTRL) ? ctrlView :
    rHitData ? rxBuf :
    hit(araddr, `SP_IDX_IE) ? ie :
    hit(araddr, `SP_IDX_OWN_STATION_ADDRESS) ? own_station_address :
    hit(araddr, `SP_IDX_MASK) ? smask :
    hit(araddr, `SP_IDX_PCTL) ? pctl :
    hit(araddr, `SP_IDX_TBSEL) ? tbsel : `SP_RST_BYTE;
  wire rMapped = hit(araddr, `SP_IDX_CTRL) || rHitData || hit(araddr, `SP_IDX_IE) ||
                 hit(araddr, `SP_IDX_OWN_STATION_ADDRESS) || hit(araddr, `SP_IDX_MASK) ||
                 hit(araddr, `SP_IDX_PCTL) || hit(araddr, `SP_IDX_TBSEL);

  // ****************************************
  // transmit fifo instance
  // ****************************************
  wire [7:0] fifoData;
  wire fifoValid;
  // mode 0 shares the pins, so transmit waits for a mode 0 receive
  wire fifoReady = txSt == TX_IDLE && !(m0 && rxSt == RX_M0);
  wire txStart = fifoValid && fifoReady;
  sp_fifo #(.WIDTH(8), .DEPTH(8)) txFifo
  (
    .clk(clk),
    .resetn(resetn),
    .inData(wDataQ),
    .inValid(wrOk && wHitData),
    .inReady(fifoInReady),
    .outData(fifoData),
    .outValid(fifoValid),
    .outReady(fifoReady)
  );

  // ****************************************
  // transmitter
  // ****************************************
  wire txBitEnd = txTick && txPh == `SP_PH_LAST;
  wire txM0End = txSt == TX_M0 && txPh == m0Last;
  // done at stop start or eighth bit end
  wire tiSet = (txSt == TX_DATA && txBitEnd && txBit == 3'h7 && !m23) ||
               (txSt == TX_NINTH && txBitEnd) || (txM0End && txBit == 3'h7);
  // start low, lsb first, stop high
  // software ninth bit in modes 2/3
  wire txLine = txSt == TX_START ? 1'b0 :
                txSt == TX_DATA ? txSh[0] :
                txSt == TX_NINTH ? txNinth : 1'b1;
  wire m0Busy = txSt == TX_M0 || rxSt == RX_M0;
  wire [3:0] m0Ph = txSt == TX_M0 ? txPh : rxPh;

  // transmit sequencing
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      txSt <= TX_IDLE;
      txBit <= 3'h0;
      txSh <= 8'h00;
      txNinth <= 1'b0;
    end
    else
    begin
      unique case (txSt)
        TX_IDLE:
          if (txStart)
          begin
            txSh <= fifoData;
            txNinth <= serial_control.tb8;
            txBit <= 3'h0;
            txSt <= m0 ? TX_M0 : TX_START;
          end
        TX_START:
          if (txBitEnd)
            txSt <= TX_DATA;
        TX_DATA:
          if (txBitEnd)
          begin
            txSh <= txSh >> 1;
            txBit <= txBit + 3'h1;
            if (txBit == 3'h7)
              txSt <= m23 ? TX_NINTH : TX_STOP;
          end
        TX_NINTH:
          if (txBitEnd)
            txSt <= TX_STOP;
        TX_STOP:
          if (txBitEnd)
            txSt <= TX_IDLE;
        TX_M0:
          if (txM0End)
          begin
            txSh <= txSh >> 1;
            txBit <= txBit + 3'h1;
            if (txBit == 3'h7)
              txSt <= TX_IDLE;
          end
      endcase
    end
  end

  // transmit phase: clocks in mode 0, ticks otherwise
  always_ff @(posedge clk)
  begin
    if (!resetn || txSt == TX_IDLE)
      txPh <= 4'h0;
    else if (txSt == TX_M0)
      txPh <= txM0End ? 4'h0 : txPh + 4'h1;
    else if (txTick)
      txPh <= txPh + 4'h1;
  end

  // pin drivers, mode 0 puts the shift clock on txd, low first half
  // shift clock on transmit pin
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      txd <= 1'b1;
      rxdOut <= 1'b1;
      rxdOe <= 1'b0;
    end
    else
    begin
      txd <= m0Busy ? (m0Ph >= m0Half) : txLine;
      rxdOut <= txSh[0];
      rxdOe <= txSt == TX_M0;
    end
  end

  // ****************************************
  // rate generation
  // ****************************************
  // prescaler and overflow halvers run all the time
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      m2Cnt <= 2'h0;
      txHalf <= 1'b0;
      rxHalf <= 1'b0;
    end
    else
    begin
      m2Cnt <= m2Tick ? 2'h0 : m2Cnt + 2'h1;
      txHalf <= txHalf ^ txOvf;
      rxHalf <= rxHalf ^ rxOvf;
    end
  end

  // ****************************************
  // receiver
  // ****************************************
  // two stages before anything looks at the pin
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      rxMeta <= 1'b1;
      rxS <= 1'b1;
    end
    else
    begin
      rxMeta <= rxd;
      rxS <= rxMeta;
    end
  end

  wire rxMid = rxTick && rxPh == `SP_PH_MID;
  wire rxBitEnd = rxTick && rxPh == `SP_PH_LAST;
  wire rxM0End = rxSt == RX_M0 && rxPh == m0Last;
  wire rxEnd = rxSt == RX_STOP && rxMid;
  wire addrOk = ((rxSh ^ own_station_address) & smask) == 8'h00;
  wire rxAccept = m23 ? (!serial_control.mp || (rxNinth && addrOk)) : (!serial_control.mp || rxS);
  wire rxM0Done = rxM0End && rxBit == 3'h7;
  // done mid stop or eighth bit end
  wire riSet = (rxEnd && rxAccept) || rxM0Done;
  wire feSet = rxEnd && !rxS && feSel;

  // receive sequencing, dropping the enable aborts a frame
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      rxSt <= RX_IDLE;
      rxBit <= 3'h0;
      rxSh <= 8'h00;
      rxNinth <= 1'b0;
    end
    else if (!serial_control.ren)
      rxSt <= RX_IDLE;
    else
    begin
      unique case (rxSt)
        RX_IDLE:
        begin
          rxBit <= 3'h0;
          // mode 0 receive waits for a clear done flag and a quiet transmitter
          if (m0)
          begin
            if (!serial_control.ri && txSt == TX_IDLE && !fifoValid)
              rxSt <= RX_M0;
          end
          else if (rxTick && !rxS)
            rxSt <= RX_START;
        end
        RX_START:
          // a high line at mid start bit is a glitch
          if (rxMid && rxS)
            rxSt <= RX_IDLE;
          else if (rxBitEnd)
            rxSt <= RX_DATA;
        RX_DATA:
        begin
          if (rxMid)
            rxSh <= {rxS, rxSh[7:1]};
          if (rxBitEnd)
          begin
            rxBit <= rxBit + 3'h1;
            if (rxBit == 3'h7)
              rxSt <= m23 ? RX_NINTH : RX_STOP;
          end
        end
        RX_NINTH:
        begin
          if (rxMid)
            rxNinth <= rxS;
          if (rxBitEnd)
            rxSt <= RX_STOP;
        end
        RX_STOP:
          if (rxMid)
            rxSt <= RX_IDLE;
        RX_M0:
          if (rxM0End)
          begin
            rxSh <= {rxS, rxSh[7:1]};
            rxBit <= rxBit + 3'h1;
            if (rxBit == 3'h7)
              rxSt <= RX_IDLE;
          end
      endcase
    end
  end

  // receive phase
  always_ff @(posedge clk)
  begin
    if (!resetn || rxSt == RX_IDLE)
      rxPh <= 4'h0;
    else if (rxSt == RX_M0)
      rxPh <= rxM0End ? 4'h0 : rxPh + 4'h1;
    else if (rxTick)
      rxPh <= rxPh + 4'h1;
  end

  // ****************************************
  // control registers
  // ****************************************
  // hardware sets win over a software clear in the same cycle
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      serial_control <= sp_serial_control_t'(`SP_RST_BYTE);
      feFlag <= 1'b0;
      ie <= `SP_RST_BYTE;
      own_station_address <= `SP_RST_BYTE;
      smask <= `SP_RST_BYTE;
      pctl <= `SP_RST_BYTE;
      tbsel <= `SP_RST_BYTE;
      rxBuf <= `SP_RST_BYTE;
    end
    else
    begin
      if (wrCtrl)
      begin
        // bit 7 role from select bit
        if (!feSel)
          serial_control.modeHi <= wDataQ[7];
        serial_control.modeLo <= wDataQ[6];
        serial_control.mp <= wDataQ[5];
        serial_control.ren <= wDataQ[4];
        serial_control.tb8 <= wDataQ[3];
      end
      feFlag <= feSet || ((wrCtrl && feSel) ? wDataQ[7] : feFlag);
      serial_control.ti <= tiSet || (wrCtrl ? wDataQ[1] : serial_control.ti);
      serial_control.ri <= riSet || (wrCtrl ? wDataQ[0] : serial_control.ri);
      // ninth data bit or stop bit
      if (rxEnd && rxAccept)
        serial_control.rb8 <= m23 ? rxNinth : rxS;
      else if (wrCtrl)
        serial_control.rb8 <= wDataQ[2];
      // receive side of the data port
      if (rxEnd && rxAccept)
        rxBuf <= rxSh;
      else if (rxM0Done)
        rxBuf <= {rxS, rxSh[7:1]};
      if (wrOk && hit(awAddrQ, `SP_IDX_IE))
        ie <= wDataQ;
      if (wrOk && hit(awAddrQ, `SP_IDX_OWN_STATION_ADDRESS))
        own_station_address <= wDataQ;
      if (wrOk && hit(awAddrQ, `SP_IDX_MASK))
        smask <= wDataQ;
      if (wrOk && hit(awAddrQ, `SP_IDX_PCTL))
        pctl <= wDataQ;
      if (wrOk && hit(awAddrQ, `SP_IDX_TBSEL))
        tbsel <= wDataQ;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      irq <= 1'b0;
    else
      irq <= ie[`SP_IE_GLOBAL] && ie[`SP_IE_SERIAL] && (serial_control.ti || serial_control.ri);
  end

  // ****************************************
  // bus slave
  // ****************************************
  // one write at a time; address and data are taken in either order
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= `SP_RESP_OKAY;
      awAddrQ <= '0;
      wDataQ <= 8'h00;
      wLaneQ <= 1'b0;
    end
    else
    begin
      if (awvalid && awready)
      begin
        awAddrQ <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready)
      begin
        wDataQ <= wdata[7:0];
        wLaneQ <= wstrb[0];
        wready <= 1'b0;
      end
      if (doWrite)
      begin
        bvalid <= 1'b1;
        bresp <= wMapped ? `SP_RESP_OKAY : `SP_RESP_SLVERR;
      end
      else if (bvalid && bready)
      begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // reads answer one cycle after the address is taken
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= `SP_RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= {24'h000000, readByte};
      rresp <= rMapped ? `SP_RESP_OKAY : `SP_RESP_SLVERR;
    end
    else if (rvalid && rready)
    begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  mode0_slow_a: assert property (($fell(txd) && txSt == TX_M0 && !serial_control.mp) |-> !txd[*6] ##1 txd)
    else $error("slow mode 0 clock low phase wrong");
  mode0_fast_a: assert property (($fell(txd) && txSt == TX_M0 && serial_control.mp) |-> !txd[*2] ##1 txd)
    else $error("fast mode 0 clock low phase wrong");
  rx_disabled_a: assert property (!serial_control.ren |=> rxSt == RX_IDLE)
    else $error("receiver active while disabled");
  frame_error_a: assert property (feSet |=> feFlag)
    else $error("frame error flag not set");
  ninth_filter_a: assert property ((rxEnd && m23 && serial_control.mp && !(rxNinth && addrOk)
    && !serial_control.ri && !wrCtrl) |=> !serial_control.ri)
    else $error("filtered frame raised receive done");
  stop_filter_a: assert property ((rxEnd && m1 && serial_control.mp && !rxS && !serial_control.ri && !wrCtrl)
    |=> !serial_control.ri)
    else $error("bad stop raised receive done");
  tx_done_a: assert property ((txSt == TX_STOP && $past(txSt) != TX_STOP) |-> serial_control.ti)
    else $error("transmit done missing at stop");
  rx_done_a: assert property ((rxEnd && rxAccept) |=> serial_control.ri && rxBuf == $past(rxSh))
    else $error("accepted frame not delivered");
  ninth_tx_a: assert property ((txSt == TX_NINTH && $past(txSt) == TX_NINTH)
    |-> txd == txNinth)
    else $error("ninth bit not on line");
  ninth_rx_a: assert property ((rxEnd && rxAccept && m23) |=> serial_control.rb8 == $past(rxNinth))
    else $error("received ninth bit not stored");
  data_read_a: assert property ((arvalid && arready && rHitData)
    |=> rdata[7:0] == $past(rxBuf))
    else $error("data port read not receive buffer");
  irq_gate_a: assert property (irq |-> $past(ie[`SP_IE_GLOBAL] && ie[`SP_IE_SERIAL])
    && $past(serial_control.ti || serial_control.ri))
    else $error("interrupt without enables or flags");
  tx_frame_c: cover property (txSt == TX_STOP && txBitEnd);
  rx_frame_c: cover property (rxEnd && rxAccept && m23);
  fe_seen_c: cover property (feSet);
  m0_byte_c: cover property (txM0End && txBit == 3'h7);
endmodule

// ===== test/serial_port_with_address_match_tb.sv
// bench for the serial port: bus tasks, fifo burst, filtered receive
`timescale 1ns/1ps
`include "sp_params.svh"
module serial_port_with_address_match_tb;
  import sp_pkg::*;
  logic clk = 0, resetn = 0, awvalid = 0, wvalid = 0, bready = 1;
  logic arvalid = 0, rready = 1, timer1Ovf = 0, timer2Ovf = 0;
  logic awready, wready, bvalid, arready, rvalid, txd, rxd, irq, ro, oe;
  logic [1:0] bresp, rresp, rs;
  logic [3:0] wstrb = 4'h0;
  sp_addr_t awaddr = '0, araddr = '0;
  sp_word_t wdata = '0, rdata, rd;
  int bad_count = 0, samples_checked = 0, cyc = 0;
  logic [31:0] seed = 73, tseed = 73;
  sp_byte_t d [10];
  sp_byte_t ri [7] = '{`SP_IDX_CTRL, `SP_IDX_DATA, `SP_IDX_IE, `SP_IDX_OWN_STATION_ADDRESS,
    `SP_IDX_MASK, `SP_IDX_PCTL, `SP_IDX_TBSEL};
  // receive cases: control, byte, ninth bit, done expected
  sp_byte_t cc [5] = '{8'h90, 8'hb0, 8'hb0, 8'hb0, 8'h80};
  sp_byte_t cd [5] = '{8'h00, 8'h5a, 8'h5a, 8'ha5, 8'h00};
  logic [4:0] cn = 5'h1c, ce = 5'h05;
  always #25 clk = ~clk;
  sp_serial_port sp_serial_port_inst (.clk(clk), .resetn(resetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .rxd(rxd), .rxdOut(ro), .rxdOe(oe), .txd(txd),
    .timer1Ovf(timer1Ovf), .timer2Ovf(timer2Ovf), .irq(irq));
  sp_far_node #(.BIT(64)) sp_far_node_inst (.clk(clk), .txd(txd), .rxd(rxd));
  // xorshift source, fixed start
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // random timer pulses and the hang limit
  always @(posedge clk)
  begin
    cyc++;
    tseed = xs(tseed);
    timer1Ovf <= tseed[0];
    timer2Ovf <= tseed[1];
    if (cyc == 40000)
    begin
      bad_count++;
      give_verdict();
    end
  end
  // bready stays high, so only valids move
  task automatic wr(input sp_byte_t idx, input sp_byte_t v);
    awaddr <= {2'b00, idx, 2'b00};
    wdata <= {24'h0, v};
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
  endtask
  task automatic rdr(input sp_byte_t idx, output sp_word_t v, output logic [1:0] r);
    araddr <= {2'b00, idx, 2'b00};
    arvalid <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    v = rdata;
    r = rresp;
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    foreach (ri[i])
    begin
      rdr(ri[i], rd, rs);
      chk(rd, 32'h0);
    end
    rdr(8'h3f, rd, rs);
    chk(32'(rs), 32'(`SP_RESP_SLVERR));
    // mode 2 burst of ten bytes, more than the 8-word fifo holds, so data writes wait
    wr(`SP_IDX_IE, 8'h90);
    wr(`SP_IDX_CTRL, 8'h98);
    foreach (d[i])
    begin
      seed = xs(seed);
      d[i] = seed[7:0];
      wr(`SP_IDX_DATA, d[i]);
    end
    while (sp_far_node_inst.got.size() < 10) @(posedge clk);
    foreach (d[i]) chk(32'(sp_far_node_inst.got[i]), {22'h0, 2'b11, d[i]});
    rdr(`SP_IDX_CTRL, rd, rs);
    chk(rd[1], 1'b1);
    chk(irq, 1'b1);
    wr(`SP_IDX_IE, 8'h10);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    // mode 0 fast byte: data leaves on the receive pin, clock rises mid bit on txd
    wr(`SP_IDX_CTRL, 8'h20);
    seed = xs(seed);
    wr(`SP_IDX_DATA, seed[7:0]);
    wait (oe === 1'b1);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge txd);
      chk(ro, seed[i]);
    end
    repeat (4) @(posedge clk);
    rdr(`SP_IDX_CTRL, rd, rs);
    chk(rd[1], 1'b1);
    wr(`SP_IDX_IE, 8'h90);
    wr(`SP_IDX_OWN_STATION_ADDRESS, 8'h5a);
    wr(`SP_IDX_MASK, 8'h0f);
    cd[0] = seed[15:8];
    cd[4] = seed[23:16];
    // plain, ninth zero, match, mismatch, receiver off
    foreach (cc[i])
    begin
      wr(`SP_IDX_CTRL, cc[i]);
      sp_far_node_inst.sendFrame(cd[i], cn[i]);
      rdr(`SP_IDX_CTRL, rd, rs);
      chk(rd[0], ce[i]);
      chk(irq, ce[i]);
      if (ce[i])
      begin
        chk(rd[2], cn[i]);
        rdr(`SP_IDX_DATA, rd, rs);
        chk(rd, {24'h0, cd[i]});
      end
    end
    give_verdict();
  end
endmodule

// ===== test/sp_far_node.sv
// far serial node: sends frames on rxd, captures frames from txd
`timescale 1ns/1ps
module sp_far_node #(parameter int BIT = 64)
(
  input wire logic clk,
  input wire logic txd,
  output logic rxd
);
  logic [9:0] got [$];  // stop, ninth, data of each captured frame
  logic [9:0] sh;
  initial rxd = 1'b1;  // idle line sits high
  task automatic sendFrame(input logic [7:0] d, input logic n);
    logic [10:0] f;
    f = {1'b1, n, d, 1'b0};
    for (int i = 0; i < 11; i++)
    begin
      rxd <= f[i];
      repeat (BIT) @(posedge clk);
    end
  endtask
  // sample mid bit after a falling start
  always
  begin
    @(posedge clk);
    if (txd === 1'b0)
    begin
      repeat (BIT / 2) @(posedge clk);
      for (int i = 0; i < 10; i++)
      begin
        repeat (BIT) @(posedge clk);
        sh[i] = txd;
      end
      got.push_back(sh);
    end
  end
endmodule
